// ---- hdl/npic_regs.svh ----
// register offsets, field positions, reset values and timing counts of the interrupt controller
// Operation
// - priority codes: level0=10, level1=01, level2=00, level3=11; level 3 masks all maskable sources
// - entering a maskable interrupt loads current priority from that vector's pair
// - top-level pin interrupt, trap and reset accepted even at level 3
// - four 8-bit priority registers hold pairs for vectors 0 to 13
// - fourth priority register: bits 7:4 read-only ones; only pairs 12, 13 writable
// - all priority registers reset to FFh, every vector at level 3
// - writing level 0 pattern into a pair keeps that pair's old value
// - reset, trap, top-level pin interrupt set both current priority bits
// - pair of the top-level pin interrupt is storage only, ignored by arbitration
// - priority rewritten during own service re-enters only if pending and higher
// - enable instruction loads 10; disable and trap load 11
// - halt, wait, flag pop, enable, disable overwrite current priority until next change
// - fixed vectors: reset FFFEh, trap FFFCh, sources 0..10 descending to FFE6h
// - only listed sources wake from HALT; trap and others do not
// - wait stops only the CPU and forces priority to fully enabled
// - WAIT lasts until any interrupt or reset, then branches to its routine
// - halt clears priority and switches the oscillator off on the same edge
// - HALT wake restarts oscillator, waits 512 CPU cycles, then services waker
// - condition flags pushed before service; restored value comes back on pop
// - after reset the device runs in RUN mode
// - highest software priority wins; ties go to fixed hardware order
// - maskable request served only if its priority exceeds current level; else pending
`ifndef NPIC_REGS_SVH
`define NPIC_REGS_SVH

`define NPIC_IDX_PRIO0      8'h2C
`define NPIC_IDX_PRIO1      8'h2D
`define NPIC_IDX_PRIO2      8'h2E
`define NPIC_IDX_PRIO3      8'h2F
`define NPIC_IDX_FLAGS      8'h30
`define NPIC_IDX_STATUS     8'h31

`define NPIC_PRIO_RST       8'hFF
`define NPIC_PRIO3_RO_MASK  8'hF0
`define NPIC_FLAGS_RST      8'hEA
`define NPIC_FLAGS_FIXED    8'hC0
`define NPIC_BIT_PRIO_HI    5
`define NPIC_BIT_PRIO_LO    3

`define NPIC_LVL0           2'h2
`define NPIC_LVL1           2'h1
`define NPIC_LVL2           2'h0
`define NPIC_LVL3           2'h3

`define NPIC_VEC_RESET      16'hFFFE
`define NPIC_VEC_TRAP       16'hFFFC
`define NPIC_VEC_SRC0       16'hFFFA
`define NPIC_NUM_SRC        11
`define NPIC_HALT_WAKE_MASK 11'h667

`define NPIC_WAKE_CYC       512

`endif

// ---- hdl/npic_pkg.sv ----
// types shared by the nested priority interrupt controller
package npic_pkg;

    typedef enum logic [1:0] {
        NPIC_RUN,
        NPIC_WAIT,
        NPIC_HALT,
        NPIC_WAKE
    } npic_state_t;

    // one instruction-boundary report from the cpu core
    typedef struct packed {
        logic       boundary;
        logic       enable_irq_instr;
        logic       sim;
        logic       halt;
        logic       wait_for_irq_instr;
        logic       trap;
        logic       irq_return_instr;
        logic       popcc;
        logic       cc_wr;
        logic [7:0] cc_val;
    } npic_cpu_op_t;

    typedef struct packed {
        logic        stop;
        logic        osc_on;
        logic        take;
        logic [15:0] vector;
        logic [7:0]  push_cc;
    } npic_cpu_ctl_t;

endpackage

// ---- hdl/npic_ctrl.sv ----
// nested priority interrupt controller with wait/halt sequencing and apb registers
`timescale 1ns/100ps
`include "npic_regs.svh"

module npic_ctrl (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire npic_pkg::npic_cpu_op_t cpu_op,
    output npic_pkg::npic_cpu_ctl_t    cpu_ctl,
    input  wire logic                  top_level_pin_irq,
    input  wire logic [10:1]           irq_req
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [1:0] prio_level(input logic [1:0] code);
        case (code)
            `NPIC_LVL0: prio_level = 2'h0;
            `NPIC_LVL1: prio_level = 2'h1;
            `NPIC_LVL2: prio_level = 2'h2;
            default:    prio_level = 2'h3;
        endcase
    endfunction

    function automatic logic [3:0] reg_decode(input logic [31:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        if (addr[1:0] != 2'h0 || addr[31:10] != 22'h0)
            reg_decode = 4'hF;
        else if (idx == `NPIC_IDX_PRIO0)
            reg_decode = 4'h0;
        else if (idx == `NPIC_IDX_PRIO1)
            reg_decode = 4'h1;
        else if (idx == `NPIC_IDX_PRIO2)
            reg_decode = 4'h2;
        else if (idx == `NPIC_IDX_PRIO3)
            reg_decode = 4'h3;
        else if (idx == `NPIC_IDX_FLAGS)
            reg_decode = 4'h4;
        else if (idx == `NPIC_IDX_STATUS)
            reg_decode = 4'h5;
        else
            reg_decode = 4'hF;
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    logic [7:0]           prio_r [4];
    logic [31:0]          prio_flat;
    logic [7:0]           cc_r;
    logic [1:0]           cur_code;
    logic [1:0]           cur_lvl;
    npic_pkg::npic_state_t st_r;
    logic [9:0]           wake_cnt_r;
    logic                 tli_s1_r;
    logic                 tli_s2_r;
    logic                 tli_s3_r;
    logic                 tli_pend_r;
    logic                 take_r;
    logic [15:0]          vec_r;
    logic [7:0]           push_r;
    logic [31:0]          rdata_r;
    logic                 sel_valid;
    logic [3:0]           sel_src;
    logic [1:0]           sel_code;
    logic [10:1]          eligible;
    logic                 take_now;
    logic                 may_take;
    logic                 apb_wr;
    logic                 apb_setup;
    logic [3:0]           wr_reg;
    logic [3:0]           rd_reg;

    assign prio_flat = {prio_r[3], prio_r[2], prio_r[1], prio_r[0]};
    assign cur_code  = {cc_r[`NPIC_BIT_PRIO_HI], cc_r[`NPIC_BIT_PRIO_LO]};
    assign cur_lvl   = prio_level(cur_code);

    // ************************************************************
    // apb slave
    // ************************************************************
    // no wait state: read data is captured in the setup phase so it leaves a flop
    assign apb_setup = psel & ~penable;
    assign apb_wr    = psel & penable & pwrite;
    assign wr_reg    = reg_decode(paddr);
    assign rd_reg    = reg_decode(paddr);
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & (wr_reg == 4'hF);
    assign prdata    = rdata_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata_r <= 32'h0;
        else if (apb_setup && !pwrite)
        begin
            if (rd_reg < 4'h4)
                rdata_r <= {24'h0, prio_r[rd_reg[1:0]]};
            else if (rd_reg == 4'h4)
                rdata_r <= {24'h0, cc_r};
            else if (rd_reg == 4'h5)
                rdata_r <= {24'h0, tli_pend_r, sel_valid, st_r, sel_src};
            else
                rdata_r <= 32'h0;
        end
    end

    // ************************************************************
    // priority registers
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_prio
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    prio_r[g] <= `NPIC_PRIO_RST;
                else if (apb_wr && wr_reg == 4'(g))
                begin
                    for (int p = 0; p < 4; p++)
                    begin
                        // a level 0 pattern leaves the pair untouched
                        if (pwdata[2*p +: 2] != `NPIC_LVL0)
                            prio_r[g][2*p +: 2] <= pwdata[2*p +: 2];
                    end
                    if (g == 3)
                        prio_r[g][7:4] <= 4'hF;
                end
            end
        end
    endgenerate

    // ************************************************************
    // pin synchroniser and top-level edge latch
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tli_s1_r <= 1'b0;
            tli_s2_r <= 1'b0;
            tli_s3_r <= 1'b0;
        end
        else
        begin
            tli_s1_r <= top_level_pin_irq;
            tli_s2_r <= tli_s1_r;
            tli_s3_r <= tli_s2_r;
        end
    end

    // new edge wins over the clear on service
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tli_pend_r <= 1'b0;
        else if (tli_s2_r && !tli_s3_r)
            tli_pend_r <= 1'b1;
        else if (take_now && !(st_r == npic_pkg::NPIC_RUN && cpu_op.trap))
            tli_pend_r <= 1'b0;
    end

    // ************************************************************
    // arbitration
    // ************************************************************
    // pair 0 belongs to the top-level source and is never looked at
    always_comb
    begin
        eligible  = irq_req;
        if (st_r == npic_pkg::NPIC_HALT || st_r == npic_pkg::NPIC_WAKE)
            eligible = irq_req & 10'(`NPIC_HALT_WAKE_MASK >> 1);
        sel_valid = 1'b0;
        sel_src   = 4'h0;
        sel_code  = `NPIC_LVL3;
        // lowest index scanned last wins on an equal or higher level
        for (int i = 10; i >= 1; i--)
        begin
            if (eligible[i] && prio_level(prio_flat[2*i +: 2]) > cur_lvl
                && (!sel_valid || prio_level(prio_flat[2*i +: 2])
                    >= prio_level(sel_code)))
            begin
                sel_valid = 1'b1;
                sel_src   = 4'(i);
                sel_code  = prio_flat[2*i +: 2];
            end
        end
    end

    // re-evaluated every cycle from live pairs and live current level
    always_comb
    begin
        case (st_r)
            npic_pkg::NPIC_RUN:  may_take = cpu_op.boundary;
            npic_pkg::NPIC_WAIT: may_take = 1'b1;
            npic_pkg::NPIC_WAKE: may_take = (wake_cnt_r == 10'h0);
            default:             may_take = 1'b0;
        endcase
        take_now = may_take && (tli_pend_r || sel_valid ||
                   (st_r == npic_pkg::NPIC_RUN && cpu_op.trap));
    end

    // ************************************************************
    // power mode sequencing
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r       <= npic_pkg::NPIC_RUN;
            wake_cnt_r <= 10'h0;
        end
        else
        begin
            case (st_r)
                npic_pkg::NPIC_RUN:
                    if (cpu_op.boundary && !take_now && cpu_op.wait_for_irq_instr)
                        st_r <= npic_pkg::NPIC_WAIT;
                    else if (cpu_op.boundary && !take_now && cpu_op.halt)
                        st_r <= npic_pkg::NPIC_HALT;
                npic_pkg::NPIC_WAIT:
                    if (take_now)
                        st_r <= npic_pkg::NPIC_RUN;
                npic_pkg::NPIC_HALT:
                    if (tli_pend_r || sel_valid)
                    begin
                        st_r       <= npic_pkg::NPIC_WAKE;
                        wake_cnt_r <= 10'(`NPIC_WAKE_CYC - 1);
                    end
                default:
                    if (wake_cnt_r == 10'h0)
                        st_r <= npic_pkg::NPIC_RUN;
                    else
                        wake_cnt_r <= wake_cnt_r - 10'h1;
            endcase
        end
    end

    // ************************************************************
    // condition flags and current priority
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cc_r <= `NPIC_FLAGS_RST;
        else if (take_now)
        begin
            if ((st_r == npic_pkg::NPIC_RUN && cpu_op.trap) || tli_pend_r)
            begin
                cc_r[`NPIC_BIT_PRIO_HI] <= 1'b1;
                cc_r[`NPIC_BIT_PRIO_LO] <= 1'b1;
            end
            else
            begin
                cc_r[`NPIC_BIT_PRIO_HI] <= sel_code[1];
                cc_r[`NPIC_BIT_PRIO_LO] <= sel_code[0];
            end
        end
        else if (st_r == npic_pkg::NPIC_RUN && cpu_op.boundary
                 && (cpu_op.irq_return_instr || cpu_op.popcc || cpu_op.enable_irq_instr || cpu_op.wait_for_irq_instr
                     || cpu_op.halt || cpu_op.sim || cpu_op.cc_wr))
        begin
            // a later change simply overwrites whatever an entry loaded
            if (cpu_op.irq_return_instr || cpu_op.popcc)
                cc_r <= cpu_op.cc_val | `NPIC_FLAGS_FIXED;
            else if (cpu_op.enable_irq_instr || cpu_op.wait_for_irq_instr || cpu_op.halt)
                {cc_r[`NPIC_BIT_PRIO_HI], cc_r[`NPIC_BIT_PRIO_LO]} <= `NPIC_LVL0;
            else if (cpu_op.sim)
                {cc_r[`NPIC_BIT_PRIO_HI], cc_r[`NPIC_BIT_PRIO_LO]} <= `NPIC_LVL3;
            else if (cpu_op.cc_wr)
                cc_r <= {2'h3, cc_r[5], cpu_op.cc_val[4], cc_r[3], cpu_op.cc_val[2:0]};
        end
        else if (apb_wr && wr_reg == 4'h4)
            cc_r <= pwdata[7:0] | `NPIC_FLAGS_FIXED;
    end

    // ************************************************************
    // service entry toward the core
    // ************************************************************
    // core pushes push_cc before fetching the vector
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            take_r <= 1'b0;
            vec_r  <= `NPIC_VEC_RESET;
            push_r <= `NPIC_FLAGS_RST;
        end
        else
        begin
            take_r <= take_now;
            if (take_now)
            begin
                push_r <= cc_r;
                if (st_r == npic_pkg::NPIC_RUN && cpu_op.trap)
                    vec_r <= `NPIC_VEC_TRAP;
                else if (tli_pend_r)
                    vec_r <= `NPIC_VEC_SRC0;
                else
                    vec_r <= `NPIC_VEC_SRC0 - {11'h0, sel_src, 1'b0};
            end
        end
    end

    assign cpu_ctl.take    = take_r;
    assign cpu_ctl.vector  = vec_r;
    assign cpu_ctl.push_cc = push_r;
    assign cpu_ctl.stop    = (st_r != npic_pkg::NPIC_RUN);
    assign cpu_ctl.osc_on  = (st_r != npic_pkg::NPIC_HALT);

    // hold by construction: pairs live in prio_r and are compared live

endmodule

// ---- verification/npic_chk.sv ----
// port checker for the interrupt controller
`timescale 1ns/100ps

module npic_chk (
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pslverr,
    input wire npic_pkg::npic_cpu_op_t  cpu_op,
    input wire npic_pkg::npic_cpu_ctl_t cpu_ctl,
    input wire logic                    top_level_pin_irq,
    input wire logic [10:1]             irq_req
);
    logic [9:0] cnt_r;
    logic       halted_r;
    logic [5:0] wake_src;

    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    assign wake_src = {irq_req[10:9], irq_req[6:5], irq_req[2:1]};

    // saturating count since restart; halted_r spans halt up to service
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r    <= 10'h000;
            halted_r <= 1'b0;
        end
        else
        begin
            cnt_r    <= !cpu_ctl.osc_on ? 10'h000 : cnt_r + {9'h000, cnt_r != 10'h3FF};
            halted_r <= !cpu_ctl.osc_on || (halted_r && cpu_ctl.stop);
        end
    end

    sequence trap_req;
        cpu_op.boundary && cpu_op.trap && !cpu_ctl.stop;
    endsequence
    sequence nmi_entry;
        cpu_ctl.take && (cpu_ctl.vector == 16'hFFFC || cpu_ctl.vector == 16'hFFFA);
    endsequence

    pslv_access_a : assert property (pslverr |-> psel && penable)
        else $error("slave error outside access phase");
    trap_taken_a : assert property (trap_req |=> nmi_entry)
        else $error("trap not taken");
    take_vec_a : assert property (cpu_ctl.take |->
        !cpu_ctl.vector[0] && cpu_ctl.vector >= 16'hFFE6)
        else $error("vector outside table");
    halt_entry_a : assert property ($fell(cpu_ctl.osc_on) |->
        $past(cpu_op.boundary && cpu_op.halt) && cpu_ctl.stop)
        else $error("oscillator off without halt");
    halt_quiet_a : assert property (!cpu_ctl.osc_on |-> !cpu_ctl.take)
        else $error("service while oscillator off");
    halt_hold_a : assert property (!cpu_ctl.osc_on && wake_src == 6'h00 &&
        !top_level_pin_irq && !$past(top_level_pin_irq) && !$past(top_level_pin_irq, 3)
        |=> !cpu_ctl.osc_on)
        else $error("halt left without wake source");
    wake_delay_a : assert property ($fell(cpu_ctl.stop) && halted_r |->
        cnt_r >= 10'h1FC && cnt_r <= 10'h204)
        else $error("wake delay wrong");
    wait_wake_a : assert property (cpu_ctl.stop && cpu_ctl.osc_on && !halted_r &&
        irq_req != 10'h000 |-> ##[1:2] cpu_ctl.take)
        else $error("wait not left on request");
endmodule

bind npic_ctrl npic_chk npic_chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pslverr(pslverr),
    .cpu_op(cpu_op), .cpu_ctl(cpu_ctl), .top_level_pin_irq(top_level_pin_irq),
    .irq_req(irq_req)
);

// ---- verification/npic_cpu_mdl.sv ----
// cpu core stand-in: boundaries, flag stack and commanded ops
`timescale 1ns/100ps

module npic_cpu_mdl (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire npic_pkg::npic_cpu_op_t  cmd,
    input  wire logic                    cmd_vld,
    input  wire npic_pkg::npic_cpu_ctl_t cpu_ctl,
    output npic_pkg::npic_cpu_op_t       cpu_op
);
    logic [7:0] stk_r [0:7];
    logic [2:0] sp_r;

    // no overflow guard: nesting stays shallow in these tests
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cpu_op <= '0;
            sp_r   <= 3'h0;
        end
        else
        begin
            cpu_op          <= cmd_vld ? cmd : '0;
            cpu_op.boundary <= !cpu_ctl.stop;
            if (cpu_ctl.take)
            begin
                stk_r[sp_r] <= cpu_ctl.push_cc;
                sp_r        <= sp_r + 3'h1;
            end
            else if (cmd_vld && cmd.irq_return_instr)
            begin
                cpu_op.cc_val <= stk_r[sp_r - 3'h1];
                sp_r          <= sp_r - 3'h1;
            end
        end
    end
endmodule

// ---- verification/tb_npic_ctrl.sv ----
// self-checking bench for the nested priority interrupt controller
`timescale 1ns/100ps

module tb_npic_ctrl;
    localparam logic [7:0] op_en   = 8'h80;
    localparam logic [7:0] op_dis  = 8'h40;
    localparam logic [7:0] op_halt = 8'h20;
    localparam logic [7:0] op_wait = 8'h10;
    localparam logic [7:0] op_trap = 8'h08;
    localparam logic [7:0] op_ret  = 8'h04;

    logic                    pclk = 1'b0;
    logic                    presetn = 1'b1;
    logic                    psel = 1'b0;
    logic                    penable = 1'b0;
    logic                    pwrite = 1'b0;
    logic [31:0]             paddr = 32'h0000_0000;
    logic [31:0]             pwdata = 32'h0000_0000;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    npic_pkg::npic_cpu_op_t  cpu_op;
    npic_pkg::npic_cpu_op_t  cmd = '0;
    logic                    cmd_vld = 1'b0;
    npic_pkg::npic_cpu_ctl_t cpu_ctl;
    logic                    pin = 1'b0;
    logic [10:1]             irq = 10'h000;
    logic [31:0]             rd;
    logic                    er;
    int                      miscompares = 0;
    int                      compares = 0;
    int                      takes = 0;
    int                      w;

    always #2.5 pclk = ~pclk;

    always @(posedge pclk)
        if (cpu_ctl.take === 1'b1)
            takes++;

    npic_ctrl npic_ctrl_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cpu_op(cpu_op), .cpu_ctl(cpu_ctl),
        .top_level_pin_irq(pin), .irq_req(irq)
    );

    npic_cpu_mdl npic_cpu_mdl_i (
        .pclk(pclk), .presetn(presetn), .cmd(cmd), .cmd_vld(cmd_vld),
        .cpu_ctl(cpu_ctl), .cpu_op(cpu_op)
    );

    task automatic test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {24'h000000, a};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        w = 0;
        do
        begin
            @(posedge pclk);
            w++;
        end
        while (pready !== 1'b1 && w < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (w >= 50)
        begin
            miscompares++;
            test_done();
        end
        @(posedge pclk);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        check(rd, {24'h000000, exp});
    endtask

    task automatic cpu(input logic [7:0] f);
        cmd     <= npic_pkg::npic_cpu_op_t'({1'b0, f, 8'h00});
        cmd_vld <= 1'b1;
        @(posedge pclk);
        cmd_vld <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wait_take(input logic [15:0] vec, input logic [7:0] cc);
        w = 0;
        while (cpu_ctl.take !== 1'b1 && w < 2000)
        begin
            @(posedge pclk);
            w++;
        end
        if (w >= 2000)
        begin
            miscompares++;
            test_done();
        end
        check({16'h0000, cpu_ctl.vector}, {16'h0000, vec});
        check({24'h000000, cpu_ctl.push_cc}, {24'h000000, cc});
    endtask

    initial
    begin
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++)
            rdchk(8'hB0 + 8'(i * 4), 8'hFF);
        rdchk(8'hC0, 8'hEA);
        apb(1'b1, 8'hC0, 8'h02);
        rdchk(8'hC0, 8'hC2);
        apb(1'b0, 8'hD0, 8'h00);
        check({31'h0, er}, 32'h1);
        check(rd, 32'h0);
        apb(1'b1, 8'hB0, 8'hCF);
        apb(1'b1, 8'hB0, 8'h64);
        rdchk(8'hB0, 8'h44);
        apb(1'b1, 8'hBC, 8'h00);
        rdchk(8'hBC, 8'hF0);
        apb(1'b1, 8'hB0, 8'h37);
        cpu(op_en);
        rdchk(8'hC0, 8'hE2);
        irq <= 10'h005;
        wait_take(16'hFFF4, 8'hE2);
        irq <= 10'h001;
        rdchk(8'hC0, 8'hC2);
        check(takes, 1);
        cpu(op_ret);
        wait_take(16'hFFF8, 8'hE2);
        irq <= 10'h000;
        rdchk(8'hC0, 8'hCA);
        cpu(op_ret);
        rdchk(8'hC0, 8'hE2);
        cpu(op_dis);
        rdchk(8'hC0, 8'hEA);
        cpu(op_trap);
        wait_take(16'hFFFC, 8'hEA);
        rdchk(8'hC0, 8'hEA);
        cpu(op_ret);
        pin <= 1'b1;
        wait_take(16'hFFFA, 8'hEA);
        pin <= 1'b0;
        cpu(op_ret);
        cpu(op_wait);
        rdchk(8'hC0, 8'hE2);
        check({31'h0, cpu_ctl.stop}, 32'h1);
        irq <= 10'h008;
        wait_take(16'hFFF2, 8'hE2);
        irq <= 10'h000;
        cpu(op_ret);
        cpu(op_halt);
        irq <= 10'h008;
        repeat (20) @(posedge pclk);
        check({30'h0, cpu_ctl.stop, cpu_ctl.osc_on}, 32'h2);
        irq <= 10'h00A;
        wait_take(16'hFFF6, 8'hE2);
        check({31'h0, w >= 512 && w <= 520}, 32'h1);
        test_done();
    end
endmodule
